//--- src/tpd_decoder.v
// Purpose: decode per-phase inputs into six gate-on commands
// Assumes: inputs synchronous to core_clk; faults arrive as levels
// Notes: single-PWM and independent schemes are not built here;
//   gate commands follow the inputs one cycle late, and a turn-on waits
//   out the dead time, so a command never leads the controller within
//   a cycle. Serial readiness and fault reporting sit beside the gate
//   path and share only the clock and reset.
`timescale 1ns/1ps
`default_nettype none
`include "tpd_regs.vh"

// Timing at a glance
// - The scheme field, or the strap, is registered once before use.
// - Decode is combinational from the phase inputs and that scheme.
// - A stage drops its gate on the edge after the request changes.
// - A stage turns a gate on only after both were off DEAD_CYCLES.
// - After reset the stages count idle time, so the first turn-on
//   also waits out the dead time.
// - Readiness counts up while enable and supply good both hold,
//   and restarts from zero when either falls.
// - Fault causes are sticky; an event in the clear cycle is kept.
// - Nothing here guards a scheme change with gates on: the
//   controller must bring all six inputs low first.
module tpd_decoder #(
	parameter READY_CYCLES = `TPD_READY_CYCLES,
	parameter DEAD_CYCLES = `TPD_DEAD_CYCLES,
	parameter FAULT_W = 5
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Scheme choice
	input wire [1:0] scheme_select,
	input wire scheme_strap_is_ground,
	// Phase inputs from the controller
	input wire [2:0] high_side_input_x,
	input wire [2:0] low_side_input_x,
	// Power-up conditions
	input wire enable,
	input wire supply_good,
	// Fault events and the software clear
	input wire [FAULT_W-1:0] fault_events,
	input wire fault_clear,
	// Gate commands, one bit per phase
	output wire [2:0] high_gate_command_x,
	output wire [2:0] low_gate_command_x,
	// Status
	output reg [1:0] active_scheme,
	output reg serial_ready,
	output reg fault_indicator_n,
	output reg [FAULT_W-1:0] fault_cause
);
	// Requests to the dead-time stages
	reg [2:0] want_high;
	reg [2:0] want_low;
	// Scheme about to be registered
	reg [1:0] next_scheme;
	// Per-scheme decode, one bit per phase
	wire [2:0] six_high;
	wire [2:0] six_low;
	wire [2:0] three_high;
	wire [2:0] three_low;
	// Power-up counter and its helpers
	reg [24:0] ready_count;
	wire [24:0] ready_last;
	wire power_up;
	wire ready_reached;
	// Fault helpers
	wire fault_seen;
	wire fault_held;

	// strap overrides the field
	// Strap wins so a board without the field still has a scheme
	always @* begin
		if (scheme_strap_is_ground)
			next_scheme = `TPD_SCHEME_SIX;
		else
			next_scheme = scheme_select;
	end

	// Scheme is registered; inputs are to be low when it changes
	// No guard against a change with gates on: the controller idles
	always @(posedge core_clk or posedge reset) begin
		if (reset)
			active_scheme <= `TPD_SCHEME_SIX;
		else
			active_scheme <= next_scheme;
	end

	// six-input: one input set drives its gate
	// Both set floats the phase rather than trusting either input
	assign six_high = high_side_input_x & ~low_side_input_x;
	assign six_low = low_side_input_x & ~high_side_input_x;

	// three-input: low input enables the phase
	// With the enable high, the high input alone picks the level
	assign three_high = low_side_input_x & high_side_input_x;
	assign three_low = low_side_input_x & ~high_side_input_x;

	// table of the active scheme feeds the stages
	// Decoding the registered scheme keeps all three phases in step
	always @* begin
		case (active_scheme)
		`TPD_SCHEME_SIX: begin
			want_high = six_high;
			want_low = six_low;
		end
		`TPD_SCHEME_THREE: begin
			want_high = three_high;
			want_low = three_low;
		end
		`TPD_SCHEME_SINGLE: begin
			want_high = 3'h0;
			want_low = 3'h0;
		end
		`TPD_SCHEME_INDEP: begin
			want_high = 3'h0;
			want_low = 3'h0;
		end
		default: begin
			want_high = 3'h0;
			want_low = 3'h0;
		end
		endcase
	end

	// phase A stage; a swap passes through both off
	// Stage sees only its own phase, so phases never wait on each other
	tpd_dead_time #(
		.DEAD(DEAD_CYCLES)
	) i_stage_a (
		.core_clk(core_clk),
		.reset(reset),
		.want_high(want_high[0]),
		.want_low(want_low[0]),
		.high_gate_command(high_gate_command_x[0]),
		.low_gate_command(low_gate_command_x[0])
	);

	// phase B stage
	// Same dead time on every phase
	tpd_dead_time #(
		.DEAD(DEAD_CYCLES)
	) i_stage_b (
		.core_clk(core_clk),
		.reset(reset),
		.want_high(want_high[1]),
		.want_low(want_low[1]),
		.high_gate_command(high_gate_command_x[1]),
		.low_gate_command(low_gate_command_x[1])
	);

	// phase C stage
	// Same dead time on every phase
	tpd_dead_time #(
		.DEAD(DEAD_CYCLES)
	) i_stage_c (
		.core_clk(core_clk),
		.reset(reset),
		.want_high(want_high[2]),
		.want_low(want_low[2]),
		.high_gate_command(high_gate_command_x[2]),
		.low_gate_command(low_gate_command_x[2])
	);

	// enable and supply good both needed; a drop restarts
	assign power_up = enable & supply_good;
	assign ready_last = READY_CYCLES[24:0] - 25'h1;
	assign ready_reached = (ready_count >= ready_last);

	// count up from enable; ready at the limit, never later
	// A 25-bit count covers a full millisecond at this clock rate
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ready_count <= 25'h0;
			serial_ready <= 1'b0;
		end else if (!power_up) begin
			ready_count <= 25'h0;
			serial_ready <= 1'b0;
		end else if (ready_reached) begin
			serial_ready <= 1'b1;
		end else begin
			ready_count <= ready_count + 25'h1;
		end
	end

	// an event now, or a cause kept past this cycle
	assign fault_seen = |fault_events;
	assign fault_held = (|fault_cause) & ~fault_clear;

	// sticky causes; a new event beats the clear
	// Set wins so a fault that lands during a clear is never lost
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fault_cause <= {FAULT_W{1'b0}};
			fault_indicator_n <= 1'b1;
		end else begin
			if (fault_clear)
				fault_cause <= fault_events;
			else
				fault_cause <= fault_cause | fault_events;
			fault_indicator_n <= ~(fault_seen | fault_held);
		end
	end
endmodule
`default_nettype wire

//--- src/tpd_regs.vh
// Purpose: constants for the three-phase input decoder
// Assumes: core_clk at 25 MHz
// Notes: scheme codes, timing figures and derived counts
`ifndef TPD_REGS_VH
`define TPD_REGS_VH
// Drive scheme codes
`define TPD_SCHEME_SIX 2'h0
`define TPD_SCHEME_THREE 2'h1
`define TPD_SCHEME_SINGLE 2'h2
`define TPD_SCHEME_INDEP 2'h3
// Clock rate in kHz
`define TPD_CLK_KHZ 25000
// Serial port ready time after enable, in ms
`define TPD_READY_MS 1
// Ready time in cycles, ms times kHz, a whole product with no rounding
`define TPD_READY_CYCLES (`TPD_READY_MS * `TPD_CLK_KHZ)
// Dead time in ns, and cycles rounded up
`define TPD_DEAD_NS 200
`define TPD_CLK_NS 40
`define TPD_DEAD_CYCLES ((`TPD_DEAD_NS + `TPD_CLK_NS - 1) / `TPD_CLK_NS)
`endif

//--- src/tpd_dead_time.v
// Purpose: one half-bridge gate stage with dead-time insertion
// Assumes: requests never ask for both gates at once
// Notes: a gate turns on only after the other has been off DEAD cycles
`timescale 1ns/1ps
`default_nettype none
module tpd_dead_time #(
	parameter DEAD = 5
) (
	input wire core_clk,
	input wire reset,
	input wire want_high,
	input wire want_low,
	output reg high_gate_command,
	output reg low_gate_command
);
	reg [7:0] off_count;
	wire want_any;
	wire same;
	assign want_any = want_high | want_low;
	assign same = (high_gate_command == want_high) &&
		(low_gate_command == want_low);
	// Turn-off is immediate; turn-on waits out the off interval
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			high_gate_command <= 1'b0;
			low_gate_command <= 1'b0;
			off_count <= 8'h00;
		end else if (same) begin
			if (!want_any && off_count != 8'hff)
				off_count <= off_count + 8'h01;
		end else if (high_gate_command | low_gate_command) begin
			// Drop both first so a swap always passes through off
			high_gate_command <= 1'b0;
			low_gate_command <= 1'b0;
			off_count <= 8'h01;
		end else if (off_count >= DEAD[7:0]) begin
			high_gate_command <= want_high;
			low_gate_command <= want_low;
		end else begin
			off_count <= off_count + 8'h01;
		end
	end
endmodule
`default_nettype wire

//--- tb/tpd_decoder_monitor.sv
// Purpose: port checks on the decoder
// Assumes: ready count of 20 cycles
// Notes: phase A stands for all phases
`timescale 1ns/1ps
`default_nettype none
module tpd_decoder_monitor #(
	parameter FAULT_W = 5
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic enable,
	input wire logic supply_good,
	input wire logic fault_clear,
	input wire logic [FAULT_W-1:0] fault_events,
	input wire logic [2:0] high_side_input_x,
	input wire logic [2:0] low_side_input_x,
	input wire logic [2:0] high_gate_command_x,
	input wire logic [2:0] low_gate_command_x,
	input wire logic [1:0] active_scheme,
	input wire logic serial_ready,
	input wire logic fault_indicator_n
);
	// One domain, so one clock and reset
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	no_shoot_a: assert property (
		~|(high_gate_command_x & low_gate_command_x)) else $error("shoot");
	dead_high_a: assert property (
		$fell(high_gate_command_x[0]) |->
		(!low_gate_command_x[0])[*5]) else $error("low too soon");
	dead_low_a: assert property (
		$fell(low_gate_command_x[0]) |->
		(!high_gate_command_x[0])[*5]) else $error("high too soon");
	six_both_a: assert property (
		(active_scheme == 2'h0 && high_side_input_x[0] &&
		low_side_input_x[0])[*3] |-> !high_gate_command_x[0] &&
		!low_gate_command_x[0]) else $error("six both");
	three_float_a: assert property (
		(active_scheme == 2'h1 && !low_side_input_x[0])[*3] |->
		!high_gate_command_x[0] && !low_gate_command_x[0])
		else $error("no float");
	unbuilt_off_a: assert property (
		active_scheme[1] && $past(active_scheme[1]) |->
		!(|{high_gate_command_x, low_gate_command_x})) else $error("gate");
	ready_drop_a: assert property (
		!(enable && supply_good) |=> !serial_ready) else $error("ready");
	ready_wait_a: assert property (
		$rose(serial_ready) |-> $past(supply_good, 16) && enable)
		else $error("early ready");
	fault_set_a: assert property (
		|fault_events |=> !fault_indicator_n) else $error("no fault");
	fault_clr_a: assert property (
		fault_clear && !(|fault_events) |=> fault_indicator_n)
		else $error("no clear");
	cover property (serial_ready);
	cover property (active_scheme == 2'h1 && |high_gate_command_x);
	cover property (!fault_indicator_n);
	cover property ($fell(high_gate_command_x[0]) ##5 low_gate_command_x[0]);
endmodule
bind tpd_decoder tpd_decoder_monitor #(.FAULT_W(FAULT_W))
	i_tpd_decoder_monitor (
	.core_clk(core_clk),
	.reset(reset),
	.enable(enable),
	.supply_good(supply_good),
	.fault_clear(fault_clear),
	.fault_events(fault_events),
	.high_side_input_x(high_side_input_x),
	.low_side_input_x(low_side_input_x),
	.high_gate_command_x(high_gate_command_x),
	.low_gate_command_x(low_gate_command_x),
	.active_scheme(active_scheme),
	.serial_ready(serial_ready),
	.fault_indicator_n(fault_indicator_n)
);
`default_nettype wire

//--- tb/tpd_ctrl_model.sv
// Purpose: controller driving phase inputs
// Assumes: code 0 float, 1 high, 2 low, 3 both
// Notes: three-input maps code 3 to a float
`timescale 1ns/1ps
`default_nettype none
module tpd_ctrl_model (
	input wire [1:0] scheme_select,
	input wire [5:0] want,
	output logic [2:0] high_side_input_x,
	output logic [2:0] low_side_input_x
);
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			high_side_input_x[i] = want[2*i];
			low_side_input_x[i] = scheme_select == 2'h1 ?
				want[2*i] ^ want[2*i+1] : want[2*i+1];
		end
	end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench
// Assumes: ready count cut to 20
// Notes: inputs change at falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 0, reset = 1, enable = 0, supply_good = 0;
	logic scheme_strap_is_ground = 0, fault_clear = 0;
	logic [1:0] scheme_select = 0;
	logic [5:0] want = 0;
	logic [4:0] fault_events = 0;
	wire [2:0] high_side_input_x, low_side_input_x;
	wire [2:0] high_gate_command_x, low_gate_command_x;
	wire [1:0] active_scheme;
	wire serial_ready, fault_indicator_n;
	wire [4:0] fault_cause;
	int n_fail = 0, checks = 0, cyc = 0;
	tpd_decoder #(
		.READY_CYCLES(20)
	) i_tpd_decoder (
		.core_clk(core_clk),
		.reset(reset),
		.scheme_select(scheme_select),
		.scheme_strap_is_ground(scheme_strap_is_ground),
		.high_side_input_x(high_side_input_x),
		.low_side_input_x(low_side_input_x),
		.enable(enable),
		.supply_good(supply_good),
		.fault_events(fault_events),
		.fault_clear(fault_clear),
		.high_gate_command_x(high_gate_command_x),
		.low_gate_command_x(low_gate_command_x),
		.active_scheme(active_scheme),
		.serial_ready(serial_ready),
		.fault_indicator_n(fault_indicator_n),
		.fault_cause(fault_cause)
	);
	tpd_ctrl_model i_tpd_ctrl_model (
		.scheme_select(scheme_select),
		.want(want),
		.high_side_input_x(high_side_input_x),
		.low_side_input_x(low_side_input_x)
	);
	// Clock and a hang limit
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			n_fail++;
			finish_test();
		end
	end
	task chk(string nm, logic [5:0] got, logic [5:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task wt(int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Expected gates: code 1 high, code 2 low
	function logic [5:0] gx(logic [5:0] w);
		for (int i = 0; i < 3; i++) begin
			gx[i] = w[2*i+:2] == 2'h1;
			gx[i+3] = w[2*i+:2] == 2'h2;
		end
	endfunction
	function logic [5:0] gates();
		return {low_gate_command_x, high_gate_command_x};
	endfunction
	// inputs zeroed before any scheme change
	task set_scheme(logic [1:0] s);
		want = 0;
		wt(3);
		scheme_select = s;
		wt(3);
		chk("scheme", active_scheme, s);
	endtask
	task t_phase(logic [1:0] s);
		set_scheme(s);
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 3; i++) want[2*i+:2] = 2'(k + i);
			wt(14);
			chk("gates", gates(), gx(want));
		end
	endtask
	task t_unbuilt;
		for (int s = 2; s < 4; s++) begin
			set_scheme(2'(s));
			want = 6'h19;
			wt(14);
			chk("off", gates(), 0);
		end
		want = 0;
		scheme_strap_is_ground = 1;
		wt(3);
		chk("strap scheme", active_scheme, 0);
		want = 6'h19;
		wt(14);
		chk("strap", gates(), gx(6'h19));
		set_scheme(2'h0);
		scheme_strap_is_ground = 0;
	endtask
	task t_ready;
		enable = 1;
		wt(10);
		chk("nosupply", serial_ready, 0);
		supply_good = 1;
		wt(22);
		chk("ready", serial_ready, 1);
		supply_good = 0;
		wt(2);
		chk("drop", serial_ready, 0);
	endtask
	task t_fault;
		fault_events = 5'h04;
		wt(2);
		fault_events = 0;
		wt(2);
		chk("cause", {fault_indicator_n, fault_cause}, 6'h04);
		fault_clear = 1;
		wt(2);
		fault_clear = 0;
		chk("clear", {fault_indicator_n, fault_cause}, 6'h20);
		fault_events = 5'h02;
		fault_clear = 1;
		wt(1);
		fault_events = 0;
		fault_clear = 0;
		wt(1);
		chk("setwins", {fault_indicator_n, fault_cause}, 6'h02);
	endtask
	// Swap of phase A passes through both off before the low gate
	task t_dead;
		set_scheme(2'h0);
		want = 6'h01;
		wt(14);
		chk("dead hi", gates(), 6'h01);
		want = 6'h02;
		wt(3);
		chk("dead", gates(), 0);
		wt(11);
		chk("swap", gates(), 6'h08);
	endtask
	task finish_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		wt(6);
		reset = 0;
		wt(2);
		t_phase(2'h0);
		t_phase(2'h1);
		t_dead;
		t_unbuilt;
		t_ready;
		t_fault;
		finish_test();
	end
endmodule
`default_nettype wire
